// ### rtl/clk_cond_pkg.sv
// Package with register map, field positions, reset values and counts for input conditioning.
package clk_cond_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] ADDR_MASTER_ONE = 8'h00;
  localparam logic [7:0] ADDR_MASTER_TWO = 8'h04;
  localparam logic [7:0] ADDR_INPUT_EN = 8'h08;
  localparam logic [7:0] ADDR_GLOBAL_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_INPUT_CTRL = 8'h10;
  localparam logic [7:0] ADDR_REF_CTRL = 8'h1c;
  localparam logic [7:0] ADDR_PLL_BASE = 8'h20;
  localparam logic [7:0] PLL_STRIDE = 8'h10;
  localparam logic [7:0] OFS_PLL_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_PLL_CTRL_THREE = 8'h04;
  localparam logic [7:0] OFS_PLL_STATUS = 8'h08;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int RING_DIS_BIT = 0;
  localparam int RING_RUN_BIT = 1;
  localparam int REF_MODE_LSB = 0;
  localparam int REF_DBL_BIT = 2;
  localparam int REF_DIV2_BIT = 3;
  localparam int REF_MCK_BIT = 4;
  localparam int IN_MCK_LSB = 5;
  localparam int PREDIV_LSB = 0;
  localparam int INVERT_BIT = 2;
  localparam int VALIDATE_INTERVAL_LSB = 8;
  localparam int MON_SW_BIT = 0;
  localparam int PIN_SW_BIT = 1;
  localparam int PRIMARY_LSB = 2;
  localparam int ALTERNATE_LSB = 4;
  localparam int LATCHED_LSB = 8;
  localparam int SELECTED_LSB = 12;

  // ************************************************************
  // Codes, reset values and counts
  // ************************************************************
  localparam logic [1:0] REF_MODE_XTAL = 2'h1;
  localparam logic [1:0] REF_MODE_SINGLE = 2'h2;
  localparam logic [1:0] REF_MODE_RESET = 2'h0;
  localparam logic [3:0] VALIDATE_INTERVAL_RESET = 4'h1;
  localparam logic [1:0] REF_INDEX = 2'h3;
  localparam logic [3:0] MISS_LIMIT_PLAIN = 4'h4;
  localparam logic [3:0] MISS_LIMIT_DOUBLED = 4'h8;
  localparam int VALID_UNIT_SHIFT = 4;

  typedef enum logic [0:0] {
    MON_INVALID = 1'b0,
    MON_VALID = 1'b1
  } mon_state_t;

endpackage

// ### rtl/clock_path.sv
// Per-input conditioning path: enable, polarity, optional doubler and power-of-two divider.
`timescale 1ns/100ps
`default_nettype none
module clock_path (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkIn,
  input wire logic pathEn,
  input wire logic invertEn,
  input wire logic doubleEn,
  input wire logic [1:0] divCode,
  output logic pulseOut
);
  import clk_cond_pkg::*;

  logic prevLvl_reg;
  logic [2:0] divCnt_reg;
  logic lvl;
  logic edgeSeen;
  logic [2:0] divMax;

  // A disabled path presents a quiet line, so its monitor falls invalid.
  assign lvl = pathEn & (clkIn ^ invertEn);
  // The doubler gives one pulse per edge of either sense.
  assign edgeSeen = doubleEn ? (lvl ^ prevLvl_reg) : (lvl & ~prevLvl_reg);
  assign divMax = 3'((4'h1 << divCode) - 4'h1);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prevLvl_reg <= 1'b0;
      divCnt_reg <= 3'h0;
      pulseOut <= 1'b0;
    end else begin
      prevLvl_reg <= lvl;
      pulseOut <= 1'b0;
      if (edgeSeen) begin
        if (divCnt_reg >= divMax) begin
          divCnt_reg <= 3'h0;
          pulseOut <= 1'b1;
        end else begin
          divCnt_reg <= divCnt_reg + 3'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/activity_monitor.sv
// Activity monitor for one input of one PLL, counting feedback clock ticks.
`timescale 1ns/100ps
`default_nettype none
module activity_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic inPulse,
  input wire logic fbTick,
  input wire logic doubled,
  input wire logic [3:0] validate_interval,
  output logic inValid
);
  import clk_cond_pkg::*;

  logic edgeTgl_reg;
  logic syncA_reg;
  logic syncB_reg;
  logic syncC_reg;
  logic [3:0] missCnt_reg;
  logic [8:0] goodCnt_reg;
  logic syncEdge;
  logic [3:0] missLimit;
  logic [8:0] goodLimit;

  // The edge toggles through two stages before the counters see it.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      edgeTgl_reg <= 1'b0;
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      syncC_reg <= 1'b0;
    end else begin
      edgeTgl_reg <= edgeTgl_reg ^ inPulse;
      syncA_reg <= edgeTgl_reg;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end

  assign syncEdge = syncB_reg ^ syncC_reg;
  assign missLimit = doubled ? MISS_LIMIT_DOUBLED : MISS_LIMIT_PLAIN;
  assign goodLimit = 9'({5'h0, validate_interval} << VALID_UNIT_SHIFT);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      missCnt_reg <= 4'h0;
      goodCnt_reg <= 9'h0;
      inValid <= MON_INVALID;
    end else if (syncEdge) begin
      missCnt_reg <= 4'h0;
    end else if (fbTick) begin
      if (missCnt_reg + 4'h1 >= missLimit) begin
        missCnt_reg <= 4'h0;
        goodCnt_reg <= 9'h0;
        inValid <= MON_INVALID;
      end else begin
        missCnt_reg <= missCnt_reg + 4'h1;
        if (goodCnt_reg >= goodLimit) begin
          inValid <= MON_VALID;
        end else begin
          goodCnt_reg <= goodCnt_reg + 9'h1;
        end
      end
    end
  end

  a_miss_drops_valid: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!syncEdge && fbTick && missCnt_reg + 4'h1 >= missLimit) |=> !inValid)
    else $error("Monitor kept valid after missing edges.");

  a_valid_after_interval: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(inValid) |-> $past(goodCnt_reg) >= $past(goodLimit))
    else $error("Monitor declared valid before the interval ended.");

endmodule
`default_nettype wire

// ### rtl/pll_input_clock_conditioning.sv
// Input clock conditioning, activity monitors and register slave for two PLLs.
// ************************************************************
// Summary of operation
// - Crystal driver runs only while reference mode holds the crystal code.
// - Reference doubler doubles the reference only while its enable bit is one.
// - Each PLL has its own input doubler, enabled by its own bit.
// - After reset the boot controller runs from the internal ring oscillator.
// - After boot completes, writing one to the disable bit halts the ring oscillator.
// - Register accesses are served without the ring oscillator or other internal clock.
// - Each differential input is active only while its enable bit is set.
// - Each differential input pre-divides by 1, 2, 4 or 8.
// - Reference path divides by 1 or 2.
// - Each differential input inverts polarity when its invert bit is set.
// - Monitor clears valid after four feedback ticks without edge, eight when doubled.
// - Monitor sets valid only after a clean programmed validation interval.
// - Each monitored input shows a real-time valid bit and a latched change bit.
// - Each monitor counts the feedback clock chosen by its select bit.
// - Two identical independent copies exist, one per PLL.
// - With monitor switching only, keep primary while valid, else take alternate.
// ************************************************************
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module pll_input_clock_conditioning (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic refPinA,
  input wire logic [2:0] diffIn,
  input wire logic [1:0] fbTick,
  input wire logic [1:0] switchPin,
  input wire logic bootDone,
  output logic crystalDriverEn,
  output logic refPathOn,
  output logic [2:0] diffInputOn,
  output logic ringOscRun,
  output logic [1:0] pllRefPulse,
  output logic [1:0][1:0] pllSelInput
);
  import clk_cond_pkg::*;

  // ************************************************************
  // Configuration state
  // ************************************************************
  logic ringOscDisable_reg;
  logic [1:0] refPinMode_reg;
  logic refDoublerEn_reg;
  logic refDivByTwo_reg;
  logic refMonClkSel_reg;
  logic [2:0] inputMonClkSel_reg;
  logic [2:0] inputEnable_reg;
  logic [1:0] inPrediv_reg [3];
  logic [2:0] inInvert_reg;
  logic [3:0] validate_interval_reg [4];
  logic [1:0] pllDblEn_reg;
  logic [1:0] monSwitchEn_reg;
  logic [1:0] pinSwitchEn_reg;
  logic [1:0] primarySel_reg [2];
  logic [1:0] alternateSel_reg [2];
  logic [3:0] latched_reg [2];
  logic [3:0] validPrev_reg [2];
  logic [1:0] srcDly_reg;
  logic [31:0] readdata_next;
  logic [3:0] inValid [2];
  logic [3:0] condPulse;
  logic [3:0] monClkSel;
  logic wrTake;
  logic wrLow;

  assign wrTake = write && !waitrequest;
  assign wrLow = wrTake && byteenable[0];
  assign monClkSel = {refMonClkSel_reg, inputMonClkSel_reg};

  // ************************************************************
  // Avalon-MM slave handshake
  // ************************************************************
  // One wait state: waitrequest drops for exactly one cycle per access. Only ref_clk is
  // used, so accesses never depend on the boot ring oscillator.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if (read || write) begin
      waitrequest <= 1'b0;
      readdata <= read ? readdata_next : 32'h0;
    end
  end

  always_comb begin
    readdata_next = 32'h0;
    case (address)
      ADDR_MASTER_ONE: begin
        readdata_next[RING_DIS_BIT] = ringOscDisable_reg;
        readdata_next[RING_RUN_BIT] = ringOscRun;
      end
      ADDR_MASTER_TWO: begin
        readdata_next[REF_MODE_LSB +: 2] = refPinMode_reg;
        readdata_next[REF_DBL_BIT] = refDoublerEn_reg;
        readdata_next[REF_DIV2_BIT] = refDivByTwo_reg;
        readdata_next[REF_MCK_BIT] = refMonClkSel_reg;
        readdata_next[IN_MCK_LSB +: 3] = inputMonClkSel_reg;
      end
      ADDR_INPUT_EN: readdata_next[2:0] = inputEnable_reg;
      ADDR_GLOBAL_STATUS: readdata_next[0] = bootDone;
      ADDR_REF_CTRL: readdata_next[VALIDATE_INTERVAL_LSB +: 4] = validate_interval_reg[3];
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (address == ADDR_INPUT_CTRL + 8'(4 * i)) begin
            readdata_next[PREDIV_LSB +: 2] = inPrediv_reg[i];
            readdata_next[INVERT_BIT] = inInvert_reg[i];
            readdata_next[VALIDATE_INTERVAL_LSB +: 4] = validate_interval_reg[i];
          end
        end
        for (int p = 0; p < 2; p++) begin
          if (address == ADDR_PLL_BASE + 8'(p * 16) + OFS_PLL_CTRL_ONE) begin
            readdata_next[0] = pllDblEn_reg[p];
          end
          if (address == ADDR_PLL_BASE + 8'(p * 16) + OFS_PLL_CTRL_THREE) begin
            readdata_next[MON_SW_BIT] = monSwitchEn_reg[p];
            readdata_next[PIN_SW_BIT] = pinSwitchEn_reg[p];
            readdata_next[PRIMARY_LSB +: 2] = primarySel_reg[p];
            readdata_next[ALTERNATE_LSB +: 2] = alternateSel_reg[p];
          end
          if (address == ADDR_PLL_BASE + 8'(p * 16) + OFS_PLL_STATUS) begin
            readdata_next[3:0] = inValid[p];
            readdata_next[LATCHED_LSB +: 4] = latched_reg[p];
            readdata_next[SELECTED_LSB +: 2] = pllSelInput[p];
          end
        end
      end
    endcase
  end

  // ************************************************************
  // Shared configuration registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ringOscDisable_reg <= 1'b0;
      refPinMode_reg <= REF_MODE_RESET;
      refDoublerEn_reg <= 1'b0;
      refDivByTwo_reg <= 1'b0;
      refMonClkSel_reg <= 1'b0;
      inputMonClkSel_reg <= 3'h0;
      inputEnable_reg <= 3'h0;
      inInvert_reg <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        inPrediv_reg[i] <= 2'h0;
      end
    end else if (wrLow) begin
      case (address)
        ADDR_MASTER_ONE: ringOscDisable_reg <= writedata[RING_DIS_BIT];
        ADDR_MASTER_TWO: begin
          refPinMode_reg <= writedata[REF_MODE_LSB +: 2];
          refDoublerEn_reg <= writedata[REF_DBL_BIT];
          refDivByTwo_reg <= writedata[REF_DIV2_BIT];
          refMonClkSel_reg <= writedata[REF_MCK_BIT];
          inputMonClkSel_reg <= writedata[IN_MCK_LSB +: 3];
        end
        ADDR_INPUT_EN: inputEnable_reg <= writedata[2:0];
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (address == ADDR_INPUT_CTRL + 8'(4 * i)) begin
              inPrediv_reg[i] <= writedata[PREDIV_LSB +: 2];
              inInvert_reg[i] <= writedata[INVERT_BIT];
            end
          end
        end
      endcase
    end
  end

  // The validation interval sits in the second byte lane; the fourth entry is the reference.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_validate_interval
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          validate_interval_reg[i] <= VALIDATE_INTERVAL_RESET;
        end else if (wrTake && byteenable[1] && address == ADDR_INPUT_CTRL + 8'(4 * i)) begin
          validate_interval_reg[i] <= writedata[VALIDATE_INTERVAL_LSB +: 4];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Oscillator, driver and input enables
  // ************************************************************
  // The ring oscillator restarts only with reset; once halted it stays halted.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ringOscRun <= 1'b1;
      crystalDriverEn <= 1'b0;
      refPathOn <= 1'b0;
      diffInputOn <= 3'h0;
    end else begin
      if (ringOscDisable_reg && bootDone) begin
        ringOscRun <= 1'b0;
      end
      crystalDriverEn <= (refPinMode_reg == REF_MODE_XTAL);
      refPathOn <= (refPinMode_reg == REF_MODE_XTAL) || (refPinMode_reg == REF_MODE_SINGLE);
      diffInputOn <= inputEnable_reg;
    end
  end

  // ************************************************************
  // Conditioning paths
  // ************************************************************
  generate
    for (genvar i = 0; i < 3; i++) begin : g_diff
      clock_path u_path (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkIn(diffIn[i]),
        .pathEn(diffInputOn[i]),
        .invertEn(inInvert_reg[i]),
        .doubleEn(1'b0),
        .divCode(inPrediv_reg[i]),
        .pulseOut(condPulse[i])
      );
    end
  endgenerate

  clock_path u_ref_path (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clkIn(refPinA),
    .pathEn(refPathOn),
    .invertEn(1'b0),
    .doubleEn(refDoublerEn_reg),
    .divCode({1'b0, refDivByTwo_reg}),
    .pulseOut(condPulse[3])
  );

  // ************************************************************
  // Per-PLL monitors, status and input mux
  // ************************************************************
  generate
    for (genvar p = 0; p < 2; p++) begin : g_pll
      logic [1:0] sel;
      logic srcPulse;

      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          pllDblEn_reg[p] <= 1'b0;
          monSwitchEn_reg[p] <= 1'b0;
          pinSwitchEn_reg[p] <= 1'b0;
          primarySel_reg[p] <= 2'h0;
          alternateSel_reg[p] <= 2'h0;
        end else if (wrLow && address == ADDR_PLL_BASE + 8'(p * 16) + OFS_PLL_CTRL_ONE) begin
          pllDblEn_reg[p] <= writedata[0];
        end else if (wrLow && address == ADDR_PLL_BASE + 8'(p * 16) + OFS_PLL_CTRL_THREE) begin
          monSwitchEn_reg[p] <= writedata[MON_SW_BIT];
          pinSwitchEn_reg[p] <= writedata[PIN_SW_BIT];
          primarySel_reg[p] <= writedata[PRIMARY_LSB +: 2];
          alternateSel_reg[p] <= writedata[ALTERNATE_LSB +: 2];
        end
      end

      for (genvar i = 0; i < 4; i++) begin : g_mon
        activity_monitor u_mon (
          .ref_clk(ref_clk),
          .reset_n(reset_n),
          .inPulse(condPulse[i]),
          .fbTick(monClkSel[i] ? fbTick[1 - p] : fbTick[p]),
          .doubled(pllDblEn_reg[p] || (i == 3 && refDoublerEn_reg)),
          .validate_interval(validate_interval_reg[i]),
          .inValid(inValid[p][i])
        );
      end

      always_comb begin
        if (pinSwitchEn_reg[p]) begin
          sel = switchPin[p] ? alternateSel_reg[p] : primarySel_reg[p];
        end else if (monSwitchEn_reg[p]) begin
          sel = inValid[p][primarySel_reg[p]] ? primarySel_reg[p] : alternateSel_reg[p];
        end else begin
          sel = primarySel_reg[p];
        end
      end

      assign srcPulse = condPulse[pllSelInput[p]];

      // The doubler adds a second pulse right after each selected one.
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          pllSelInput[p] <= 2'h0;
          srcDly_reg[p] <= 1'b0;
          pllRefPulse[p] <= 1'b0;
        end else begin
          pllSelInput[p] <= sel;
          srcDly_reg[p] <= srcPulse;
          pllRefPulse[p] <= srcPulse || (pllDblEn_reg[p] && srcDly_reg[p]);
        end
      end

      // A change of state wins over a clear arriving in the same cycle.
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          validPrev_reg[p] <= 4'h0;
          latched_reg[p] <= 4'h0;
        end else begin
          validPrev_reg[p] <= inValid[p];
          if (wrTake && byteenable[1] && address == ADDR_PLL_BASE + 8'(p * 16) + OFS_PLL_STATUS) begin
            latched_reg[p] <= (latched_reg[p] & ~writedata[LATCHED_LSB +: 4])
              | (inValid[p] ^ validPrev_reg[p]);
          end else begin
            latched_reg[p] <= latched_reg[p] | (inValid[p] ^ validPrev_reg[p]);
          end
        end
      end

      a_latched_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (latched_reg[p] != 4'h0 && !wrTake) |=> (latched_reg[p] & $past(latched_reg[p]))
        == $past(latched_reg[p]))
        else $error("Latched status dropped without a clear.");

      a_mon_switch_sel: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (monSwitchEn_reg[p] && !pinSwitchEn_reg[p] && !inValid[p][primarySel_reg[p]])
        |=> pllSelInput[p] == $past(alternateSel_reg[p]))
        else $error("Mux did not fall back to the alternate input.");
    end
  endgenerate

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_req_wait;
    (read || write) && waitrequest;
  endsequence

  sequence s_ack_then_idle;
    ##[1:2] !waitrequest ##1 waitrequest;
  endsequence

  a_bus_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_req_wait |-> s_ack_then_idle)
    else $error("Bus access not answered in time.");

  a_xtal_drv_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 crystalDriverEn == ($past(refPinMode_reg) == REF_MODE_XTAL))
    else $error("Crystal driver state disagrees with reference mode.");

  a_ring_boot_run: assert property (@(posedge ref_clk)
    (!$past(reset_n) && reset_n) |-> ringOscRun)
    else $error("Ring oscillator not running after reset.");

  a_ring_stop_cause: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(ringOscRun) |-> $past(bootDone) && $past(ringOscDisable_reg))
    else $error("Ring oscillator halted without boot done and disable.");

  a_diff_enable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 diffInputOn == $past(inputEnable_reg))
    else $error("Input enable not followed.");

endmodule
`default_nettype wire

// ### dv/clk_source.sv
// External clock source model for the reference pin and three differential inputs.
`timescale 1ns/100ps
`default_nettype none
module clk_source (
  input wire logic ref_clk,
  input wire logic [3:0] runMask,
  output logic refPinA,
  output logic [2:0] diffIn
);
  logic phaseReg = 1'b0;
  // The pin acts as a precise external oscillator, so internal load caps are never used.
  initial begin
    refPinA = 1'b0;
    diffIn = 3'h0;
  end
  // All sources share one rate, so they divide to one common detector frequency.
  always @(posedge ref_clk) begin
    phaseReg <= ~phaseReg;
    if (phaseReg) begin
      diffIn <= diffIn ^ runMask[2:0];
      refPinA <= refPinA ^ runMask[3];
    end
  end
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking testbench for the input clock conditioning block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import clk_cond_pkg::*;
  logic ref_clk, reset_n, read, write, bootDone, waitrequest, refPinA;
  logic crystalDriverEn, refPathOn, ringOscRun;
  logic [7:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable, runMask;
  logic [2:0] diffIn, diffInputOn;
  logic [1:0] fbTick, switchPin, pllRefPulse, tickCnt;
  logic [1:0][1:0] pllSelInput;
  int nFail = 0;
  int nTests = 0;
  pll_input_clock_conditioning DUT (.ref_clk, .reset_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .refPinA, .diffIn, .fbTick, .switchPin, .bootDone,
    .crystalDriverEn, .refPathOn, .diffInputOn, .ringOscRun, .pllRefPulse, .pllSelInput);
  clk_source SRC (.ref_clk, .runMask, .refPinA, .diffIn);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Feedback ticks every fourth cycle, the same for both PLLs.
  always @(posedge ref_clk) begin
    tickCnt <= tickCnt + 2'h1;
    fbTick <= {2{tickCnt == 2'h0}};
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task wrapUp;
    if (nFail == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // The request stands until waitrequest is sampled low; read data is taken at that edge.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // Counts the cycles that carry a reference pulse on each PLL over a window.
  task pulses(input int n, output int c0, output int c1);
    c0 = 0;
    c1 = 0;
    repeat (n) begin
      @(negedge ref_clk);
      c0 += pllRefPulse[0];
      c1 += pllRefPulse[1];
    end
    @(posedge ref_clk);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task tModes;
    @(negedge ref_clk);
    chk("ringOscRun", 32'h1, ringOscRun);
    @(posedge ref_clk);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, ADDR_MASTER_TWO, c);
      @(negedge ref_clk);
      chk("crystalDriverEn", c == 1, crystalDriverEn);
      chk("refPathOn", c == 1 || c == 2, refPathOn);
      @(posedge ref_clk);
    end
    rchk("masterTwo", ADDR_MASTER_TWO, 32'h3);
    bus(1'b1, ADDR_MASTER_TWO, 32'h0);
    bus(1'b1, ADDR_INPUT_EN, 32'h5);
    bus(1'b1, 8'hfc, 32'hffffffff);
    rchk("unmapped", 8'hfc, 32'h0);
    rchk("inputEn", ADDR_INPUT_EN, 32'h5);
    @(negedge ref_clk);
    chk("diffInputOn", 32'h5, diffInputOn);
    @(posedge ref_clk);
  endtask
  task tRing;
    bus(1'b1, ADDR_MASTER_ONE, 32'h1);
    @(negedge ref_clk);
    chk("ringOscRun", 32'h1, ringOscRun);
    @(posedge ref_clk);
    rchk("bootStatus", ADDR_GLOBAL_STATUS, 32'h0);
    bootDone <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("ringOscRun", 32'h0, ringOscRun);
    @(posedge ref_clk);
    rchk("bootStatus", ADDR_GLOBAL_STATUS, 32'h1);
  endtask
  // Only input one runs; it is validated, lost and switched away from.
  task tMonitor;
    int c0, c1;
    bus(1'b1, ADDR_INPUT_EN, 32'h1);
    runMask <= 4'h1;
    repeat (150) @(posedge ref_clk);
    rchk("statusOne", 8'h28, 32'h101);
    rchk("statusTwo", 8'h38, 32'h101);
    // The second PLL doubles its selected source, here a differential one; a selected reference path output is doubled as well.
    bus(1'b1, 8'h30, 32'h1);
    pulses(40, c0, c1);
    chk("pulsesOne", 32'ha, c0);
    chk("pulsesTwo", 32'h14, c1);
    bus(1'b1, 8'h28, 32'h100);
    rchk("statusClear", 8'h28, 32'h1);
    bus(1'b1, 8'h24, 32'h11);
    bus(1'b1, 8'h34, 32'h12);
    switchPin <= 2'h2;
    runMask <= 4'h0;
    repeat (60) @(posedge ref_clk);
    rchk("statusLost", 8'h28, 32'h1100);
    @(negedge ref_clk);
    chk("pllSelOne", 32'h1, pllSelInput[0]);
    chk("pllSelTwo", 32'h1, pllSelInput[1]);
    @(posedge ref_clk);
  endtask
  initial begin
    reset_n = 1'b0;
    {read, write, bootDone, address, writedata, runMask, switchPin, fbTick, tickCnt} = '0;
    byteenable = 4'hf;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    tModes;
    tRing;
    tMonitor;
    wrapUp;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    nFail++;
    wrapUp;
  end
endmodule
`default_nettype wire
